/* shared/lrs_consts.svh */
/*
  constants for the reservation / sanitize descriptor checker:
  opcodes, field positions, status and sense codes, register map.
  assumes nothing; included by package and design files.
*/
`ifndef LRS_CONSTS_SVH
`define LRS_CONSTS_SVH

`define LRS_OP_REZERO 8'h01
`define LRS_OP_RSV6 8'h16
`define LRS_OP_SANITIZE 8'h48
`define LRS_OP_RSV10 8'h56
`define LRS_SA_OVERWRITE 5'h01
`define LRS_SA_CRYPTO 5'h03
`define LRS_SA_EXIT 5'h1f
`define LRS_BIT_EXT 0
`define LRS_BIT_3RD 4
`define LRS_BIT_IMMED 7
`define LRS_BIT_ALLOW_EXIT 5
`define LRS_ST_GOOD 8'h00
`define LRS_ST_CHECK 8'h02
`define LRS_ST_CONFLICT 8'h18
`define LRS_SK_NONE 4'h0
`define LRS_SK_ILLEGAL 4'h5
`define LRS_ASC_NONE 8'h00
`define LRS_ASC_INV_CDB 8'h24
`define LRS_REG_STATUS 12'h000
`define LRS_REG_IRQ 12'h004
`define LRS_REG_MASK 12'h008
`define LRS_REG_SAN_CTRL 12'h00c
`define LRS_SAN_TIME_US 100
`define LRS_SAN_CYCLES (`LRS_SAN_TIME_US * 100)
`define LRS_IRQ_W 4

`endif

/* shared/lrs_pkg.sv */
/*
  types for the reservation / sanitize descriptor checker.
  assumes lrs_consts.svh is on the include path.
*/
`include "lrs_consts.svh"
package lrs_pkg;
  // one received descriptor with its issuing initiator
  typedef struct packed {
    logic [3:0] initiator;
    logic [9:0][7:0] cdb;
  } lrs_cmd_t;

  // answer to one descriptor
  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } lrs_resp_t;

  // verdict from the field checker
  typedef enum logic [2:0] {
    LRS_V_GOOD, LRS_V_INVALID, LRS_V_CONFLICT, LRS_V_SEEK,
    LRS_V_SANITIZE, LRS_V_OTHER
  } lrs_verdict_t;
endpackage

/* design/lrs_cdb_check.sv */
/*
  combinational field checker for one descriptor.
  assumes reservation holder state supplied by the caller.
*/
`timescale 1ns/100ps
`include "lrs_consts.svh"
module lrs_cdb_check (
  input lrs_pkg::lrs_cmd_t cmd,
  input logic held,
  input logic [3:0] holder,
  input logic fail_latched,
  input logic fail_exit_ok,
  output lrs_pkg::lrs_verdict_t verdict
);
  import lrs_pkg::*;
  logic [7:0] op;
  logic [7:0] b1;
  logic [4:0] sa;
  logic [15:0] plen;
  assign op = cmd.cdb[0];
  assign b1 = cmd.cdb[1];
  assign sa = b1[4:0];
  assign plen = {cmd.cdb[7], cmd.cdb[8]};

  // decode; control byte link/flag and id bytes never examined
  always_comb
  begin
    verdict = LRS_V_OTHER;
    case (op)
      `LRS_OP_RSV6, `LRS_OP_RSV10:
      begin
        if (b1[`LRS_BIT_EXT])
          verdict = LRS_V_INVALID;
        else if (b1[`LRS_BIT_3RD])
          verdict = LRS_V_INVALID;
        else if (held && holder != cmd.initiator)
          verdict = LRS_V_CONFLICT;
        else
          verdict = LRS_V_GOOD;
      end
      `LRS_OP_REZERO: verdict = LRS_V_SEEK;
      `LRS_OP_SANITIZE:
      begin
        if (sa != `LRS_SA_OVERWRITE && sa != `LRS_SA_CRYPTO &&
            sa != `LRS_SA_EXIT)
          verdict = LRS_V_INVALID;
        else if (sa != `LRS_SA_OVERWRITE && plen != 16'h0000)
          verdict = LRS_V_INVALID;
        else if (sa == `LRS_SA_EXIT && fail_latched && !fail_exit_ok)
          verdict = LRS_V_INVALID;
        else
          verdict = LRS_V_SANITIZE;
      end
      default: verdict = LRS_V_OTHER;
    endcase
  end
endmodule

/* design/lrs_apb_regs.sv */
/*
  apb slave: sticky event status, mask, sanitize control, status readback.
  assumes apb master on the same clock; one-cycle answers.
*/
`timescale 1ns/100ps
`include "lrs_consts.svh"
module lrs_apb_regs (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`LRS_IRQ_W-1:0] events,
  input wire logic [7:0] state_bits,
  output logic san_fail_req,
  output logic irq
);
  import lrs_pkg::*;
  logic [`LRS_IRQ_W-1:0] sts_q, sts_d, msk_q, msk_d;
  logic fail_q, fail_d;
  logic [31:0] rd_q, rd_d;
  logic err_q, err_d;
  logic acc, wr;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  assign prdata = rd_q;
  assign pslverr = err_q;
  assign san_fail_req = fail_q;
  assign irq = |(sts_q & msk_q);

  // register next values; a set wins over a write-one clear
  always_comb
  begin
    sts_d = sts_q;
    msk_d = msk_q;
    fail_d = fail_q;
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (wr && paddr == `LRS_REG_IRQ)
      sts_d = sts_q & ~pwdata[`LRS_IRQ_W-1:0];
    sts_d = sts_d | events;
    if (wr && paddr == `LRS_REG_MASK)
      msk_d = pwdata[`LRS_IRQ_W-1:0];
    if (wr && paddr == `LRS_REG_SAN_CTRL)
      fail_d = pwdata[0];
    if (psel && !penable)
    begin
      case (paddr)
        `LRS_REG_STATUS: rd_d = {24'h000000, state_bits};
        `LRS_REG_IRQ: rd_d = {28'h0000000, sts_q};
        `LRS_REG_MASK: rd_d = {28'h0000000, msk_q};
        `LRS_REG_SAN_CTRL: rd_d = {31'h00000000, fail_q};
        default: err_d = 1'b1;
      endcase
    end
    else if (acc)
    begin
      rd_d = rd_q;
      err_d = err_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sts_q <= '0;
      msk_q <= '0;
      fail_q <= 1'b0;
      rd_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else
    begin
      sts_q <= sts_d;
      msk_q <= msk_d;
      fail_q <= fail_d;
      rd_q <= rd_d;
      err_q <= err_d;
    end
  end
endmodule

/* design/lrs_checker.sv */
/*
  top of the descriptor checker: takes descriptors, holds the unit
  reservation, runs sanitize and seek requests, answers with status
  and sense, and carries the apb register block.

  command side
    a descriptor is taken at a rising edge with cmd_valid high and
    busy low; resp_valid pulses one cycle later and resp stands
    until the next answer or a taken foreground sanitize (good, no sense) replaces it.
    a foreground sanitize answers when its count runs out; commands
    that arrive meanwhile are dropped without an answer.
    a readiness poll in the same cycle as a command is dropped.

  reservation side
    a good six-byte or ten-byte reservation grants the whole unit to
    its initiator; the holder may renew it whenever busy is low.
    another initiator gets a conflict answer and nothing changes.
    release_valid drops the reservation only when release_initiator
    is the holder; target_reset and hard_reset drop it for anyone.
    held and holder show the reservation as registered levels.
    the reservation id, the third party id, the extent length and
    the control byte are never looked at.

  sanitize side
    SAN_CYCLES sets how many cycles one sanitize runs.
    with the immediate bit set the answer is good at once and the run
    goes on in the background: busy stays low, unit_ready is low.
    a poll during a background run answers check, no sense key.
    a run that fails latches the failure together with its allow
    bit; the exit action clears the failure at once when allowed.

  sequencer states
    idle: no sanitize runs; foreground: busy high, answer pending;
    background: answer already given, run still counting.

  register side
    zero-wait apb slave; status readback, sticky events with a
    write-one clear, event mask, and a test hook in the sanitize
    control word that makes the following runs fail.
    events: bit 0 check answer, bit 1 conflict answer,
    bit 2 sanitize done, bit 3 seek to block zero.
    irq is high while an unmasked event bit is set.
    pready is tied high; pslverr flags an unmapped offset.

  assumes cmd_valid is a one-cycle pulse on clock, one command at a time,
  and target_reset/hard_reset pulses from logic on the same clock.
*/
// Register access over APB and the placing of the registers were left to the implementer.
// How it works
// - reservation command reserves whole unit
// - extent bit set gives invalid field
// - third party bit set gives invalid field
// - id byte and extent length ignored
// - ten-byte third party id ignored
// - reservation kept until release or reset
// - only holder releases or supersedes
// - other initiator gets reservation conflict
// - return-to-zero seeks block zero
// - sanitize decodes immed, allow, action, length
// - immed returns good at once
// - failed sanitize without allow blocks exit
// - non-overwrite with length is invalid
// - link and flag bits ignored
// - only three sanitize actions accepted
`timescale 1ns/100ps
`include "lrs_consts.svh"
module lrs_checker #(
  parameter int unsigned SAN_CYCLES = `LRS_SAN_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input lrs_pkg::lrs_cmd_t cmd,
  input wire logic release_valid,
  input wire logic [3:0] release_initiator,
  input wire logic target_reset,
  input wire logic hard_reset,
  input wire logic tur_valid,
  output logic busy,
  output logic resp_valid,
  output lrs_pkg::lrs_resp_t resp,
  output logic unit_ready,
  output logic seek_zero,
  output logic held,
  output logic [3:0] holder,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import lrs_pkg::*;

  // idle, foreground run, background run
  typedef enum logic [1:0] {LRS_IDLE, LRS_SAN_WAIT, LRS_SAN_BG} lrs_state_t;

  // sequencing state
  lrs_state_t st_q, st_d;
  // reservation, failure latch and allow bit
  logic held_q, held_d;
  logic [3:0] holder_q, holder_d;
  logic fail_q, fail_d;
  logic allow_q, allow_d;
  // sanitize countdown
  logic [31:0] cnt_q, cnt_d;
  // registered answer and seek pulse
  logic rv_q, rv_d;
  lrs_resp_t resp_q, resp_d;
  logic seek_q, seek_d;
  // glue between checker, registers and sequencer
  logic [`LRS_IRQ_W-1:0] ev;
  lrs_verdict_t verdict;
  logic san_fail_req;
  logic san_done;
  logic immed;

  // field checker sees the registered reservation
  // only opcode/byte1/length bytes read
  lrs_cdb_check u_check (
    .cmd(cmd),
    .held(held_q),
    .holder(holder_q),
    .fail_latched(fail_q),
    .fail_exit_ok(allow_q),
    .verdict(verdict)
  );

  assign immed = cmd.cdb[1][`LRS_BIT_IMMED];
  assign san_done = (cnt_q == 32'd1);
  // status outputs
  assign busy = (st_q == LRS_SAN_WAIT);
  assign resp_valid = rv_q;
  assign resp = resp_q;
  assign seek_zero = seek_q;
  assign held = held_q;
  assign holder = holder_q;
  assign unit_ready = (st_q == LRS_IDLE);

  // event sources for the interrupt status
  assign ev[0] = rv_q && resp_q.status == `LRS_ST_CHECK;
  assign ev[1] = rv_q && resp_q.status == `LRS_ST_CONFLICT;
  assign ev[2] = (st_q != LRS_IDLE) && san_done;
  assign ev[3] = seek_q;

  // register block; state readback packs failure, allow, held and holder bits 2:0
  lrs_apb_regs u_regs (
    .clock(clock),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .events(ev),
    .state_bits({2'b00, fail_q, allow_q, held_q, holder_q[2:0]}),
    .san_fail_req(san_fail_req),
    .irq(irq)
  );

  // command handling, reservation state and sanitize sequencing
  always_comb
  begin
    // defaults: hold state, answer and seek are pulses
    st_d = st_q;
    held_d = held_q;
    holder_d = holder_q;
    fail_d = fail_q;
    allow_d = allow_q;
    cnt_d = cnt_q;
    rv_d = 1'b0;
    resp_d = resp_q;
    seek_d = 1'b0;
    // sanitize running in the background or foreground
    if (st_q != LRS_IDLE)
    begin
      // count stops at zero so done cannot repeat
      if (cnt_q != 32'd0)
        cnt_d = cnt_q - 32'd1;
      if (san_done)
      begin
        st_d = LRS_IDLE;
        // failure latch follows the test hook
        fail_d = san_fail_req;
        if (st_q == LRS_SAN_WAIT)
        begin
          rv_d = 1'b1;
          resp_d.status = san_fail_req ? `LRS_ST_CHECK : `LRS_ST_GOOD;
          resp_d.sense_key = `LRS_SK_NONE;
          resp_d.asc = `LRS_ASC_NONE;
        end
      end
    end
    // readiness poll answers good or check
    if (tur_valid && !cmd_valid && st_q != LRS_SAN_WAIT)
    begin
      rv_d = 1'b1;
      resp_d.status = (st_q == LRS_IDLE) ? `LRS_ST_GOOD : `LRS_ST_CHECK;
      resp_d.sense_key = `LRS_SK_NONE;
      resp_d.asc = `LRS_ASC_NONE;
    end
    // one descriptor; dropped while a foreground run is busy
    if (cmd_valid && st_q != LRS_SAN_WAIT)
    begin
      rv_d = 1'b1;
      resp_d.status = `LRS_ST_GOOD;
      resp_d.sense_key = `LRS_SK_NONE;
      resp_d.asc = `LRS_ASC_NONE;
      case (verdict)
        LRS_V_GOOD:
        begin
          held_d = 1'b1;
          holder_d = cmd.initiator;
        end
        LRS_V_INVALID:
        begin
          resp_d.status = `LRS_ST_CHECK;
          resp_d.sense_key = `LRS_SK_ILLEGAL;
          resp_d.asc = `LRS_ASC_INV_CDB;
        end
        LRS_V_CONFLICT: resp_d.status = `LRS_ST_CONFLICT;
        LRS_V_SEEK: seek_d = 1'b1;
        LRS_V_SANITIZE:
        begin
          // exit action: failure cleared, answer good
          if (cmd.cdb[1][4:0] == `LRS_SA_EXIT)
          begin
            fail_d = 1'b0;
          end
          else
          begin
            allow_d = cmd.cdb[1][`LRS_BIT_ALLOW_EXIT];
            // start a new run
            cnt_d = SAN_CYCLES;
            if (immed)
              st_d = LRS_SAN_BG;
            else
            begin
              st_d = LRS_SAN_WAIT;
              rv_d = 1'b0;
            end
          end
        end
        // other opcodes answer good
        default: resp_d.status = `LRS_ST_GOOD;
      endcase
    end
    // release and resets come last so they win over a grant
    // release only by holder
    if (release_valid && held_q && release_initiator == holder_q)
      held_d = 1'b0;
    if (target_reset || hard_reset)
      held_d = 1'b0;
  end

  // state registers, synchronous reset
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_q <= LRS_IDLE;
      held_q <= 1'b0;
      holder_q <= 4'h0;
      fail_q <= 1'b0;
      allow_q <= 1'b0;
      cnt_q <= 32'd0;
      rv_q <= 1'b0;
      resp_q <= '0;
      seek_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      held_q <= held_d;
      holder_q <= holder_d;
      fail_q <= fail_d;
      allow_q <= allow_d;
      cnt_q <= cnt_d;
      rv_q <= rv_d;
      resp_q <= resp_d;
      seek_q <= seek_d;
    end
  end
endmodule

/* tb/lrs_props.sv */
/* assertions on the descriptor checker top ports.
   assumes one clock with synchronous srst; bound below. */
`timescale 1ns/100ps
`include "lrs_consts.svh"
module lrs_props (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input lrs_pkg::lrs_cmd_t cmd,
  input wire logic target_reset,
  input wire logic busy,
  input wire logic resp_valid,
  input lrs_pkg::lrs_resp_t resp,
  input wire logic held,
  input wire logic [3:0] holder
);
  import lrs_pkg::*;
  logic go, rsv, san, inv;
  logic [4:0] sa;
  logic [15:0] len;
  // accepted command kinds and the invalid-field answer
  assign go = cmd_valid && !busy;
  assign rsv = go && cmd.cdb[0][2] && !cmd.cdb[0][3];
  assign san = go && !held && cmd.cdb[0] == `LRS_OP_SANITIZE;
  assign sa = cmd.cdb[1][4:0];
  assign len = {cmd.cdb[7], cmd.cdb[8]};
  assign inv = resp_valid && resp ==
    {`LRS_ST_CHECK, `LRS_SK_ILLEGAL, `LRS_ASC_INV_CDB};
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  grant_whole_a: assert property (rsv && sa == 5'h0 && !held
    |=> held && holder == $past(cmd.initiator))
    else $error("reservation not granted");
  ext_rejected_a: assert property (rsv && cmd.cdb[1][0] |=> inv)
    else $error("extent bit accepted");
  third_rejected_a: assert property (rsv && cmd.cdb[1][4] |=> inv)
    else $error("third party bit accepted");
  reserve_conflict_a: assert property (rsv && held && sa == 5'h0
    && cmd.initiator != holder |=> resp_valid
    && resp.status == `LRS_ST_CONFLICT && $stable(holder))
    else $error("foreign reservation not refused");
  reset_clear_a: assert property (target_reset && !cmd_valid
    |=> !held) else $error("reservation survived reset");
  san_code_a: assert property (san && sa != `LRS_SA_OVERWRITE
    && sa != `LRS_SA_CRYPTO && sa != `LRS_SA_EXIT |=> inv)
    else $error("bad action accepted");
  san_length_a: assert property (san && len != 16'h0
    && sa != `LRS_SA_OVERWRITE |=> inv)
    else $error("length accepted");
  immed_good_a: assert property (san && cmd.cdb[1][7]
    && sa == `LRS_SA_CRYPTO && len == 16'h0
    |=> resp_valid && resp.status == `LRS_ST_GOOD)
    else $error("immediate status missing");
endmodule
bind lrs_checker lrs_props u_props (.clock, .srst, .cmd_valid, .cmd,
  .target_reset, .busy, .resp_valid, .resp, .held, .holder);

/* tb/lrs_host.sv */
/* initiator model: descriptors and one-cycle pulses.
   assumes the bench calls send and strobe. */
`timescale 1ns/100ps
module lrs_host (
  input wire logic clock,
  output lrs_pkg::lrs_cmd_t cmd,
  output logic cmd_valid,
  output logic [3:0] pulse,
  output logic [3:0] rel_ini
);
  import lrs_pkg::*;
  // idle values at time zero
  initial
  begin
    cmd_valid = 1'h0;
    cmd = '0;
    pulse = 4'h0;
    rel_ini = 4'h0;
  end
  // one descriptor for one cycle, then scrambled
  task automatic send(input logic [3:0] i, input logic [9:0][7:0] c);
    int k;
    k = c[0] < 8'h20 ? 5 : 9;
    c[k][1] = c[k][1] & c[k][0];
    @(posedge clock);
    cmd_valid <= 1'h1;
    cmd <= {i, c};
    @(posedge clock);
    cmd_valid <= 1'h0;
    cmd <= ~{i, c};
  endtask
  // 0 release, 1 target reset, 2 hard reset, 3 poll
  task automatic strobe(input int b, input logic [3:0] i);
    @(posedge clock);
    pulse[b] <= 1'h1;
    rel_ini <= i;
    @(posedge clock);
    pulse[b] <= 1'h0;
    rel_ini <= ~i;
  endtask
endmodule

/* tb/lrs_checker_tb.sv */
/* bench: random reservations, sanitize codes, apb registers.
   assumes lrs_host and the bound assertion checker. */
`timescale 1ns/100ps
`include "lrs_consts.svh"
module lrs_checker_tb;
  import lrs_pkg::*;
  logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic cmd_valid, busy, resp_valid, unit_ready, seek_zero, held;
  logic pready, pslverr, irq, err, m_held = 0, m_fail = 0, m_allow = 0;
  logic [3:0] pulse, rel_ini, holder, m_holder = 0;
  logic [7:0] b;
  logic [9:0][7:0] c;
  lrs_cmd_t cmd;
  lrs_resp_t resp;
  int bad_count = 0, num_checks = 0;
  initial
  begin
    forever #5 clock = ~clock;
  end
  lrs_checker #(.SAN_CYCLES(5)) DUT (.clock, .srst, .cmd_valid, .cmd,
    .release_valid(pulse[0]), .release_initiator(rel_ini),
    .target_reset(pulse[1]), .hard_reset(pulse[2]), .tur_valid(pulse[3]),
    .busy, .resp_valid, .resp, .unit_ready, .seek_zero, .held, .holder,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq);
  lrs_host host (.clock, .cmd, .cmd_valid, .pulse, .rel_ini);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [19:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_hi(input string n, ref logic s);
    for (int k = 0; s !== 1'h1; k++)
    begin
      if (k > 40)
      begin
        chk(n, 0, 1);
        end_sim();
      end
      @(posedge clock);
      #1;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int k;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    // access phase lasts until an edge samples pready high
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1)
    begin
      chk("pready", 0, 1);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  // random fill of ignored bytes and link/flag bits
  function automatic logic [79:0] mk(input logic [7:0] op, b1,
    input logic [15:0] n);
    logic [9:0][7:0] r;
    r = '0;
    r[0] = op;
    r[1] = b1;
    r[2] = op[2] ? 8'($urandom) : 8'h0;
    r[3] = op[2] ? 8'($urandom) : 8'h0;
    r[7] = n[15:8];
    r[8] = n[7:0];
    r[op < 8'h20 ? 5 : 9] = 8'($urandom % 4);
    return r;
  endfunction
  // expected answer from the reference state
  function automatic logic [19:0] want(input logic [3:0] i);
    logic [4:0] s;
    s = c[1][4:0];
    if (c[0][2] && !c[0][3])
    begin
      if (c[1][0] || c[1][4])
        return {`LRS_ST_CHECK, `LRS_SK_ILLEGAL, `LRS_ASC_INV_CDB};
      if (m_held && m_holder != i)
        return {`LRS_ST_CONFLICT, 12'h0};
      m_held = 1'h1;
      m_holder = i;
    end
    if (c[0] == `LRS_OP_SANITIZE)
    begin
      if (!(s inside {5'h01, 5'h03, 5'h1f}) || (s != 5'h01 &&
        {c[7], c[8]} != 0) || (s == 5'h1f && m_fail && !m_allow))
        return {`LRS_ST_CHECK, `LRS_SK_ILLEGAL, `LRS_ASC_INV_CDB};
      m_fail = s == 5'h1f ? 1'h0 : m_fail;
    end
    return 20'h0;
  endfunction
  task automatic run(input logic [3:0] i);
    logic [19:0] e;
    logic w;
    e = want(i);
    // a good non-immediate run, not the exit action, holds busy
    w = c[0] == `LRS_OP_SANITIZE && e == 20'h0 && !c[1][7] &&
      c[1][4:0] != `LRS_SA_EXIT;
    host.send(i, c);
    #1;
    chk("seek", seek_zero, c[0] == `LRS_OP_REZERO);
    chk("busy", busy, w);
    wait_hi("resp_valid", resp_valid);
    chk("status", resp.status, e[19:12]);
    if (e[19:12] == `LRS_ST_CHECK)
      chk("sense", resp[11:0], e[11:0]);
    chk("held", held, m_held);
    if (m_held)
      chk("holder", holder, m_holder);
  endtask
  task automatic pul(input int k, input logic [3:0] i);
    host.strobe(k, i);
    #1;
    if (k != 0 || i == m_holder)
      m_held = 1'h0;
    chk("held", held, m_held);
  endtask
  initial
  begin
    void'($urandom(85252));
    repeat (20) @(posedge clock);
    srst <= 1'h0;
    apb(0, `LRS_REG_IRQ, 0);
    chk("irq_reg", rd[19:0], 0);
    repeat (80)
    begin
      if ($urandom % 4 == 0)
        pul($urandom % 3, 4'($urandom % 3));
      b = $urandom % 3 == 0 ? 8'($urandom) & 8'h11 : 8'h0;
      c = mk($urandom % 2 ? `LRS_OP_RSV6 : `LRS_OP_RSV10, b, 16'($urandom));
      run(4'($urandom % 3));
    end
    pul(2, 0);
    c = mk(`LRS_OP_RSV6, 0, 0);
    run(5);
    apb(1, `LRS_REG_STATUS, 0);
    apb(0, `LRS_REG_STATUS, 0);
    chk("status_reg", rd[3:0], 4'hd);
    pul(0, 5);
    apb(1, `LRS_REG_IRQ, 32'hf);
    c = mk(`LRS_OP_REZERO, 0, 0);
    run(1);
    apb(0, `LRS_REG_IRQ, 0);
    chk("seek_event", rd[3:0], 4'h8);
    apb(1, `LRS_REG_MASK, 32'hf);
    chk("irq_on", irq, 1);
    apb(1, `LRS_REG_MASK, 0);
    chk("irq_mask", irq, 0);
    apb(1, `LRS_REG_IRQ, 32'hf);
    chk("irq_clear", irq, 0);
    apb(0, `LRS_REG_IRQ, 0);
    chk("irq_sts_clr", rd[3:0], 0);
    apb(1, 12'h010, 0);
    chk("unmapped", err, 1);
    for (int s = 0; s < 32; s++)
    begin
      c = mk(`LRS_OP_SANITIZE, {1'($urandom), 2'h0, 5'(s)},
        s == 1 || $urandom % 2 ? 16'($urandom % 9 + 1) : 16'h0);
      run(0);
      wait_hi("ready", unit_ready);
    end
    for (int a = 0; a < 2; a++)
    begin
      apb(1, `LRS_REG_SAN_CTRL, 1);
      c = mk(`LRS_OP_SANITIZE, {2'h2, 1'(a), 5'h03}, 0);
      run(0);
      host.strobe(3, 0);
      #1;
      chk("poll", resp.status, `LRS_ST_CHECK);
      chk("not_ready", unit_ready, 0);
      wait_hi("ready", unit_ready);
      m_fail = 1'h1;
      m_allow = 1'(a);
      c = mk(`LRS_OP_SANITIZE, 8'h1f, 0);
      run(0);
    end
    end_sim();
  end
endmodule
